// ---- src/rtc_map.vh ----
// Register map, command fields and constants of the serial clock block
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// Command byte fields
`define RTC_CMD_WE      7
`define RTC_CMD_RAM     6
`define RTC_CMD_ADDR    5:1
`define RTC_CMD_RD      0

// Clock and RAM space locations
`define RTC_A_SEC       5'h00
`define RTC_A_MIN       5'h01
`define RTC_A_HR        5'h02
`define RTC_A_DATE      5'h03
`define RTC_A_MON       5'h04
`define RTC_A_DAY       5'h05
`define RTC_A_YR        5'h06
`define RTC_A_CTL       5'h07
`define RTC_A_CHG       5'h08
`define RTC_A_BURST     5'h1F
`define RTC_CLK_LAST    5'h07
`define RTC_RAM_LAST    5'h1E

// Bit fields
`define RTC_HALT_BIT    7
`define RTC_H12_BIT     7
`define RTC_PM_BIT      5
`define RTC_WP_BIT      7
`define RTC_TCS_FLD     7:4
`define RTC_DS_FLD      3:2
`define RTC_RS_FLD      1:0
`define RTC_TCS_ON      4'hA
`define RTC_DS_ONE      2'h1
`define RTC_DS_TWO      2'h2
`define RTC_RS_NONE     2'h0

// Reset values
`define RTC_SEC_RST     8'h80
`define RTC_ONE_RST     8'h01
`define RTC_ZERO_RST    8'h00
`define RTC_WP_RST      1'b1

// Counting limits in BCD
`define RTC_BCD_59      7'h59
`define RTC_BCD_12      8'h12
`define RTC_BCD_99      8'h99
`define RTC_DAY_MAX     8'h07
`define RTC_H12_MAX     5'h12
`define RTC_H12_PRE     5'h11
`define RTC_H24_MAX     6'h23

// Serial framing, write queue and crystal divider
`define RTC_BIT_LAST    3'h7
`define RTC_ENT_W       14
`define RTC_FIFO_DEPTH  32
`define RTC_OSC_DIV     32768

`endif

// ---- src/rtc_wr_fifo.v ----
// Write queue between the serial port and the register file
`timescale 1ns/1ps
module rtc_wr_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             clk_sys_i,
    input  wire             rst_i,
    // Fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];  // Storage, no reset needed
    reg [AW-1:0]    wr_q;               // Write pointer
    reg [AW-1:0]    rd_q;               // Read pointer
    reg [AW:0]      cnt_q;              // Fill level

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_q];

    // ----------------------------------------
    // Storage write
    // ----------------------------------------
    always @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // ----------------------------------------
    // Pointers and level
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            // Pointers wrap at DEPTH, which need not be a power of two
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule // rtc_wr_fifo

// ---- src/serial_rtc_with_ram.v ----
// Serial clock/calendar with scratch RAM, write protect and charger setup
`timescale 1ns/1ps
`include "rtc_map.vh"
module serial_rtc_with_ram #(
    parameter OSC_DIV = `RTC_OSC_DIV,   // Crystal edges per second
    parameter PRE_W   = 15,             // Prescaler width
    parameter FDEPTH  = `RTC_FIFO_DEPTH // Write queue depth
) (
    // System clock and reset
    input  wire       clk_sys_i,
    input  wire       rst_i,
    // Three-wire serial port
    input  wire       xfer_en_i,
    input  wire       sclk_i,
    input  wire       sdat_i,
    output reg        sdat_o,
    output reg        sdat_oe_o,
    // Timebase from the crystal oscillator
    input  wire       crystal_pins_i,
    // Status and charger control
    output reg        osc_halted_o,
    output reg        charger_on_o,
    output reg  [1:0] diode_select_o,
    output reg  [1:0] resistor_select_o
);

    // ----------------------------------------
    // Serial phases
    // ----------------------------------------
    localparam [1:0] P_CMD  = 2'h0;     // Shifting the command byte
    localparam [1:0] P_WR   = 2'h1;     // Taking write data
    localparam [1:0] P_RD   = 2'h2;     // Sending read data
    localparam [1:0] P_DONE = 2'h3;     // Ignoring further clocks

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg        en_s1, en_s2;            // Enable synchroniser
    reg        ck_s1, ck_s2, ck_s3;     // Serial clock synchroniser and history
    reg        dt_s1, dt_s2;            // Data synchroniser
    reg        xt_s1, xt_s2, xt_s3;     // Crystal synchroniser and history
    reg  [1:0] phase_q;                 // Transfer phase
    reg  [2:0] bit_q;                   // Bit position in the byte
    reg  [7:0] shf_q;                   // Input shift register
    reg  [7:0] rdsh_q;                  // Byte being sent
    reg        ram_q;                   // Space: RAM when set
    reg        wen_q;                   // Command allows writes
    reg        burst_q;                 // Burst transfer
    reg  [4:0] addr_q;                  // Current location
    reg  [7:0] stg_q [0:7];             // Clock burst staging
    reg        flush_q;                 // Staging being queued
    reg  [2:0] fidx_q;                  // Next staged entry
    reg        pend_q;                  // Single entry waiting
    reg  [13:0] pend_d_q;               // Its contents
    reg  [7:0] sec_q, min_q, hr_q;      // Time registers
    reg  [7:0] date_q, mon_q, day_q;    // Calendar registers
    reg  [7:0] yr_q, chg_q;             // Year and charger setup
    reg        wp_q;                    // Write protect
    reg  [7:0] ram_q_mem [0:30];        // Scratch RAM
    reg  [PRE_W-1:0] pre_q;             // Crystal prescaler
    reg        tick_q;                  // One-second pulse
    reg  [7:0] rd_byte;                 // Read mux
    wire       rise = ck_s2 & ~ck_s3;
    wire       fall = ~ck_s2 & ck_s3;
    wire [7:0] shin = {dt_s2, shf_q[7:1]};
    wire       f_in_rdy, f_out_vld;
    wire [13:0] f_out;
    wire       f_in_vld = pend_q | flush_q;
    wire [13:0] f_in = pend_q ? pend_d_q : {1'b0, 2'b00, fidx_q, stg_q[fidx_q]};
    wire       drain_rdy = ~tick_q;     // Ticks take the registers first
    wire       fire = f_out_vld & drain_rdy;
    wire       e_ram = f_out[13];
    wire [4:0] e_addr = f_out[12:8];
    wire [7:0] e_dat = f_out[7:0];
    wire       e_blk = wp_q & ~(~e_ram & (e_addr == `RTC_A_CTL));

    // ----------------------------------------
    // BCD helpers
    // ----------------------------------------
    // Next BCD value, no wrap
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
                                       : {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // Last date of a month; years divisible by four are leap
    function [7:0] mlen;
        input [7:0] m;
        input [7:0] y;
        reg         leap;
        begin
            leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                        : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
            case (m)
                8'h02:   mlen = leap ? 8'h29 : 8'h28;
                8'h04, 8'h06, 8'h09, 8'h11: mlen = 8'h30;
                default: mlen = 8'h31;
            endcase
        end
    endfunction

    // Next hour in either format, format bits kept
    function [7:0] hr_next;
        input [7:0] h;
        reg   [7:0] t;
        begin
            t = 8'h00;
            if (h[`RTC_H12_BIT]) begin
                t = bcd_inc({3'h0, h[4:0]});
                if (h[4:0] == `RTC_H12_MAX) begin
                    hr_next = {h[7:5], 5'h01};
                end else if (h[4:0] == `RTC_H12_PRE) begin
                    hr_next = {h[7:6], ~h[`RTC_PM_BIT], `RTC_H12_MAX};
                end else begin
                    hr_next = {h[7:5], t[4:0]};
                end
            end else begin
                t = bcd_inc({2'h0, h[5:0]});
                hr_next = (h[5:0] == `RTC_H24_MAX) ? {h[7:6], 6'h00}
                                                   : {h[7:6], t[5:0]};
            end
        end
    endfunction

    // Carry chain of the timekeeping counters
    wire s_wrap = (sec_q[6:0] == `RTC_BCD_59);
    wire m_wrap = s_wrap & (min_q[6:0] == `RTC_BCD_59);
    wire h_end  = hr_q[`RTC_H12_BIT] ? (hr_q[`RTC_PM_BIT] & (hr_q[4:0] == `RTC_H12_PRE))
                                     : (hr_q[5:0] == `RTC_H24_MAX);
    wire h_wrap = m_wrap & h_end;
    wire d_wrap = h_wrap & (date_q == mlen(mon_q, yr_q));
    wire y_wrap = d_wrap & (mon_q == `RTC_BCD_12);
    wire [7:0] s_inc = bcd_inc({1'b0, sec_q[6:0]});

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Pins come from another domain; second stage feeds the logic
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            {en_s1, en_s2, dt_s1, dt_s2} <= 4'h0;
            {ck_s1, ck_s2, ck_s3} <= 3'h0;
            {xt_s1, xt_s2, xt_s3} <= 3'h0;
        end else begin
            {en_s1, en_s2} <= {xfer_en_i, en_s1};
            {dt_s1, dt_s2} <= {sdat_i, dt_s1};
            {ck_s1, ck_s2, ck_s3} <= {sclk_i, ck_s1, ck_s2};
            {xt_s1, xt_s2, xt_s3} <= {crystal_pins_i, xt_s1, xt_s2};
        end
    end

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    always @* begin
        rd_byte = 8'h00;
        if (ram_q) begin
            if (addr_q != `RTC_A_BURST) begin
                rd_byte = ram_q_mem[addr_q];
            end
        end else begin
            case (addr_q)
                `RTC_A_SEC:  rd_byte = sec_q;
                `RTC_A_MIN:  rd_byte = min_q;
                `RTC_A_HR:   rd_byte = hr_q;
                `RTC_A_DATE: rd_byte = date_q;
                `RTC_A_MON:  rd_byte = mon_q;
                `RTC_A_DAY:  rd_byte = day_q;
                `RTC_A_YR:   rd_byte = yr_q;
                `RTC_A_CTL:  rd_byte = {wp_q, 7'h00};   // Low bits read zero
                `RTC_A_CHG:  rd_byte = chg_q;
                default:     rd_byte = 8'h00;           // No storage
            endcase
        end
    end

    // ----------------------------------------
    // Serial engine
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q   <= P_CMD;
            bit_q     <= 3'h0;
            shf_q     <= 8'h00;
            rdsh_q    <= 8'h00;
            ram_q     <= 1'b0;
            wen_q     <= 1'b0;
            burst_q   <= 1'b0;
            addr_q    <= 5'h00;
            sdat_o    <= 1'b0;
            sdat_oe_o <= 1'b0;
            flush_q   <= 1'b0;
            fidx_q    <= 3'h0;
            pend_q    <= 1'b0;
            pend_d_q  <= 14'h0000;
        end else begin
            // Queue hand-off; the fill side stalls on a full queue
            if (pend_q & f_in_rdy) begin
                pend_q <= 1'b0;
            end else if (flush_q & f_in_rdy) begin
                fidx_q <= fidx_q + 3'h1;
                if (fidx_q == `RTC_BIT_LAST) begin
                    flush_q <= 1'b0;
                end
            end
            if (!en_s2) begin
                // Enable low ends the transfer, pin released
                phase_q   <= P_CMD;
                bit_q     <= 3'h0;
                sdat_oe_o <= 1'b0;
            end else if (rise) begin
                if (phase_q != P_DONE) begin
                    shf_q <= shin;          // LSB arrives first
                    bit_q <= bit_q + 3'h1;
                end
                if (phase_q == P_CMD && bit_q == `RTC_BIT_LAST) begin
                    // Decode the command byte
                    ram_q   <= shin[`RTC_CMD_RAM];
                    wen_q   <= shin[`RTC_CMD_WE];
                    burst_q <= (shin[`RTC_CMD_ADDR] == `RTC_A_BURST);
                    // Burst starts at location zero
                    addr_q  <= (shin[`RTC_CMD_ADDR] == `RTC_A_BURST) ? 5'h00
                                                                    : shin[`RTC_CMD_ADDR];
                    phase_q <= shin[`RTC_CMD_RD] ? P_RD : P_WR;
                end else if (phase_q == P_RD) begin
                    sdat_oe_o <= 1'b0;      // Released on every rise
                    if (bit_q == `RTC_BIT_LAST && burst_q) begin
                        // Stream continues while enabled
                        if (addr_q == (ram_q ? `RTC_RAM_LAST : `RTC_CLK_LAST)) begin
                            addr_q <= 5'h00;
                        end else begin
                            addr_q <= addr_q + 5'h01;
                        end
                    end
                end else if (phase_q == P_WR && bit_q == `RTC_BIT_LAST) begin
                    // Whole byte in hand; nothing changes before this
                    if (!burst_q) begin
                        phase_q <= P_DONE;  // Later clocks ignored
                        if (wen_q) begin    // Command bit 7 gates writes
                            pend_q   <= 1'b1;
                            pend_d_q <= {ram_q, addr_q, shin};
                        end
                    end else if (ram_q) begin
                        // Each RAM byte goes out at once
                        if (wen_q) begin
                            pend_q   <= 1'b1;
                            pend_d_q <= {1'b1, addr_q, shin};
                        end
                        addr_q <= addr_q + 5'h01;
                        if (addr_q == `RTC_RAM_LAST) begin
                            phase_q <= P_DONE;
                        end
                    end else begin
                        // Clock burst staged until all eight arrive
                        stg_q[addr_q[2:0]] <= shin;
                        addr_q <= addr_q + 5'h01;
                        if (addr_q == `RTC_CLK_LAST) begin
                            phase_q <= P_DONE;
                            // Protected burst moves nothing
                            if (wen_q && !wp_q) begin
                                flush_q <= 1'b1;
                                fidx_q  <= 3'h0;
                            end
                        end
                    end
                end
            end else if (fall && phase_q == P_RD) begin
                // Bits leave on falls, first one right after the command
                sdat_oe_o <= 1'b1;
                if (bit_q == 3'h0) begin
                    rdsh_q <= rd_byte;
                    sdat_o <= rd_byte[0];
                end else begin
                    sdat_o <= rdsh_q[bit_q];
                end
            end
        end
    end

    // ----------------------------------------
    // Write queue instance
    // ----------------------------------------
    rtc_wr_fifo #(
        .WIDTH (`RTC_ENT_W),
        .DEPTH (FDEPTH),
        .AW    (5)
    ) u_wr_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (f_in_vld),
        .in_ready_o  (f_in_rdy),
        .in_data_i   (f_in),
        .out_valid_o (f_out_vld),
        .out_ready_i (drain_rdy),
        .out_data_o  (f_out)
    );

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    // Counts crystal rises; frozen while halted
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q  <= {PRE_W{1'b0}};
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (!sec_q[`RTC_HALT_BIT] && xt_s2 && !xt_s3) begin
                if (pre_q == OSC_DIV[PRE_W-1:0] - 1'b1) begin
                    pre_q  <= {PRE_W{1'b0}};
                    tick_q <= 1'b1;
                end else begin
                    pre_q <= pre_q + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Register file: ticks and queued writes
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sec_q  <= `RTC_SEC_RST;
            min_q  <= `RTC_ZERO_RST;
            hr_q   <= `RTC_ZERO_RST;
            date_q <= `RTC_ONE_RST;
            mon_q  <= `RTC_ONE_RST;
            day_q  <= `RTC_ONE_RST;
            yr_q   <= `RTC_ZERO_RST;
            wp_q   <= `RTC_WP_RST;
            chg_q  <= `RTC_ZERO_RST;   // Charger starts disabled
        end else if (tick_q) begin
            // BCD counting with carries
            sec_q <= {sec_q[`RTC_HALT_BIT], s_wrap ? 7'h00 : s_inc[6:0]};
            if (s_wrap) begin
                min_q <= (m_wrap) ? 8'h00 : bcd_inc(min_q);
            end
            if (m_wrap) begin
                hr_q <= hr_next(hr_q);  // Format bits preserved
            end
            if (h_wrap) begin
                day_q  <= (day_q == `RTC_DAY_MAX) ? 8'h01 : day_q + 8'h01;
                date_q <= d_wrap ? 8'h01 : bcd_inc(date_q);
            end
            if (d_wrap) begin
                mon_q <= y_wrap ? 8'h01 : bcd_inc(mon_q);
            end
            if (y_wrap) begin
                yr_q <= (yr_q == `RTC_BCD_99) ? 8'h00 : bcd_inc(yr_q);
            end
        end else if (fire && !e_ram && !e_blk) begin
            // Protect blocks all but the control byte
            case (e_addr)
                `RTC_A_SEC:  sec_q  <= e_dat;   // Halt bit written here
                `RTC_A_MIN:  min_q  <= e_dat;
                `RTC_A_HR:   hr_q   <= e_dat;
                `RTC_A_DATE: date_q <= e_dat;
                `RTC_A_MON:  mon_q  <= e_dat;
                `RTC_A_DAY:  day_q  <= e_dat;
                `RTC_A_YR:   yr_q   <= e_dat;
                `RTC_A_CTL:  wp_q   <= e_dat[`RTC_WP_BIT];
                `RTC_A_CHG:  chg_q  <= e_dat;
                default:     ;                  // Unbacked location
            endcase
        end
    end

    // ----------------------------------------
    // Scratch RAM writes
    // ----------------------------------------
    // Location 31 has no cell behind it
    always @(posedge clk_sys_i) begin
        if (fire && e_ram && !e_blk && e_addr != `RTC_A_BURST) begin
            ram_q_mem[e_addr] <= e_dat;
        end
    end

    // ----------------------------------------
    // Status and charger outputs
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            osc_halted_o      <= 1'b1;
            charger_on_o      <= 1'b0;
            diode_select_o    <= 2'h0;
            resistor_select_o <= 2'h0;
        end else begin
            osc_halted_o <= sec_q[`RTC_HALT_BIT];
            // Only the exact pattern with valid diode and resistor
            if (chg_q[`RTC_TCS_FLD] == `RTC_TCS_ON &&
                (chg_q[`RTC_DS_FLD] == `RTC_DS_ONE || chg_q[`RTC_DS_FLD] == `RTC_DS_TWO) &&
                chg_q[`RTC_RS_FLD] != `RTC_RS_NONE) begin
                charger_on_o      <= 1'b1;
                diode_select_o    <= chg_q[`RTC_DS_FLD];
                resistor_select_o <= chg_q[`RTC_RS_FLD];
            end else begin
                charger_on_o      <= 1'b0;
                diode_select_o    <= 2'h0;
                resistor_select_o <= 2'h0;
            end
        end
    end

endmodule // serial_rtc_with_ram

// ---- test/serial_host_model.sv ----
// Host model driving the three-wire serial port
`timescale 1ns/1ps
module serial_host_model (
    input  wire  clk_sys_i,
    input  wire  sdat_o,
    input  wire  sdat_oe_o,
    output logic xfer_en_o,
    output logic sclk_o,
    output wire  sdat_line_o
);
    logic       drv_q = 0;   // Host owns the data line
    logic       bit_q = 0;   // Bit the host presents
    logic       last_q = 0;  // Last driven level; a released line shows its inverse
    logic [7:0] buf_q [32];  // Bytes sent or received
    assign sdat_line_o = sdat_oe_o ? sdat_o : (drv_q ? bit_q : ~last_q);
    initial {xfer_en_o, sclk_o} = 2'h0;
    always @(posedge clk_sys_i) if (sdat_oe_o || drv_q) last_q <= sdat_line_o;
    // Half of the 32 ns link clock
    task automatic half();
        repeat (4) @(negedge clk_sys_i);
    endtask
    // Command then nb data bits; clock low when enable rises
    task automatic run(input logic [7:0] cmd, input int nb);
        xfer_en_o = 1'b1;
        half();
        for (int i = 0; i < 8 + nb; i++) begin
            drv_q = !(cmd[0] && i >= 8);
            bit_q = (i < 8) ? cmd[i%8] : buf_q[i/8-1][i%8];
            half();
            if (!drv_q) buf_q[i/8-1][i%8] = sdat_line_o;
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
        end
        half();
        {xfer_en_o, drv_q} = 2'h0;
        half();
    endtask
endmodule // serial_host_model

// ---- test/serial_rtc_with_ram_properties.sv ----
// Port checker of the serial clock block
`timescale 1ns/1ps
module serial_rtc_with_ram_properties (
    input wire       clk_sys_i, rst_i, xfer_en_i, sclk_i, sdat_i, sdat_o, sdat_oe_o,
    input wire       crystal_pins_i, osc_halted_o, charger_on_o,
    input wire [1:0] diode_select_o, resistor_select_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    oe_idle_a: assert property ((!xfer_en_i) [*5] |-> !sdat_oe_o)
        else $error("pin driven idle");
    oe_after_fall_a: assert property ($rose(sdat_oe_o) |-> !$past(sclk_i, 2))
        else $error("drive without fall");
    oe_release_a: assert property ($fell(sdat_oe_o) |-> $past(sclk_i, 2) || !$past(xfer_en_i, 2))
        else $error("early release");
    bit_hold_a: assert property (sdat_oe_o && $past(sdat_oe_o) |-> $stable(sdat_o))
        else $error("bit changed");
    diode_legal_a: assert property (charger_on_o |-> diode_select_o inside {2'h1, 2'h2})
        else $error("bad diode");
    resistor_legal_a: assert property (charger_on_o |-> resistor_select_o != 2'h0)
        else $error("bad resistor");
    selects_off_a: assert property (!charger_on_o |-> {diode_select_o, resistor_select_o} == 4'h0)
        else $error("selects while off");
    reset_state_a: assert property ($fell(rst_i) |-> !charger_on_o && osc_halted_o)
        else $error("bad reset state");
    cover property ($rose(charger_on_o));
    cover property ($fell(osc_halted_o));
    cover property ($rose(sdat_oe_o));
endmodule // serial_rtc_with_ram_properties
bind serial_rtc_with_ram serial_rtc_with_ram_properties u_props (.clk_sys_i, .rst_i,
    .xfer_en_i, .sclk_i, .sdat_i, .sdat_o, .sdat_oe_o, .crystal_pins_i, .osc_halted_o,
    .charger_on_o, .diode_select_o, .resistor_select_o);

// ---- test/tb_serial_rtc_with_ram.sv ----
// Self-checking bench of the serial clock block
`timescale 1ns/1ps
module tb_serial_rtc_with_ram;
    logic       clk_sys_i = 0, rst_i = 1, crystal_pins_i = 0;
    wire        xfer_en_i, sclk_i, sdat_i, sdat_o, sdat_oe_o, osc_halted_o, charger_on_o;
    wire  [1:0] diode_select_o, resistor_select_o;
    int         n_errors = 0, n_checks = 0, cyc = 0;
    // Short second keeps the tick test brief
    serial_rtc_with_ram #(.OSC_DIV(4)) DUT (.clk_sys_i, .rst_i, .xfer_en_i, .sclk_i,
        .sdat_i, .sdat_o, .sdat_oe_o, .crystal_pins_i, .osc_halted_o, .charger_on_o,
        .diode_select_o, .resistor_select_o);
    serial_host_model host (.clk_sys_i, .sdat_o, .sdat_oe_o, .xfer_en_o(xfer_en_i),
        .sclk_o(sclk_i), .sdat_line_o(sdat_i));
    initial forever #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (++cyc == 30000) begin
        n_errors++;
        complete_run();
    end
    task automatic chk(input string what, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] cmd, d);
        host.buf_q[0] = d;
        host.run(cmd, 8);
    endtask
    task automatic rd(input logic [7:0] cmd, exp, input string what);
        host.run(cmd, 8);
        chk(what, host.buf_q[0], exp);
    endtask
    // Protect set after reset, extra clocks, refused command, unbacked place
    task automatic t_protect();
        rd(8'h8F, 8'h80, "control");
        wr(8'h80, 8'h00);
        chk("halt", osc_halted_o, 8'h01);
        host.buf_q[1] = 8'h80;
        host.run(8'h8E, 16);
        wr(8'h0E, 8'h80);
        rd(8'h8F, 8'h00, "control");
        wr(8'h92, 8'h55);
        rd(8'h93, 8'h00, "unbacked");
    endtask
    // Enabled, wrong pattern, no resistor, bad diode
    task automatic t_charger();
        logic [7:0] v [5] = '{8'hA5, 8'hAA, 8'hA4, 8'hAD, 8'hB5};
        for (int i = 0; i < 5; i++) begin
            wr(8'h90, v[i]);
            chk("charger", {charger_on_o, diode_select_o, resistor_select_o},
                i < 2 ? {1'b1, v[i][3:0]} : 8'h00);
            rd(8'h91, v[i], "setup");
        end
        // Mid-run reset with the charger on: it comes back off and protected
        wr(8'h90, 8'hA5);
        rst_i = 1;
        @(negedge clk_sys_i) rst_i = 0;
        @(negedge clk_sys_i);
        chk("charger", charger_on_o, 8'h00);
        rd(8'h8F, 8'h80, "control");
        wr(8'h8E, 8'h00);
    endtask
    // Short RAM burst, then a write cut off mid-byte
    task automatic t_ram();
        host.buf_q[0] = 8'h3C;
        host.buf_q[1] = 8'hC3;
        host.run(8'hFE, 16);
        rd(8'hC3, 8'hC3, "ram1");
        wr(8'hC0, 8'hFF);
        host.buf_q[0] = 8'h00;      // Cut byte differs, so a partial commit would show
        host.run(8'hC0, 5);
        rd(8'hC1, 8'hFF, "ram0");
    endtask
    // Partial and full clock burst, a tick in each hour format, wrapping burst read
    task automatic t_clock();
        logic [7:0] e [9] = '{0, 0, 0, 8'h29, 8'h02, 8'h01, 0, 0, 0};
        logic [7:0] s [8] = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h07, 0, 0};
        foreach (s[i]) host.buf_q[i] = s[i];
        host.run(8'hBE, 24);
        chk("halt", osc_halted_o, 8'h01);
        for (int r = 0; r < 2; r++) begin
            s[2] = r ? 8'hB1 : 8'h23;   // Second pass: 11 PM in 12-hour format
            e[2] = r ? 8'h92 : 8'h00;   // Becomes 12 AM, format bit kept
            foreach (s[i]) host.buf_q[i] = s[i];
            host.run(8'hBE, 64);
            chk("halt", osc_halted_o, 8'h00);
            repeat (8) begin
                repeat (5) @(negedge clk_sys_i);
                crystal_pins_i = ~crystal_pins_i;
            end
            host.run(8'hBF, 72);
            foreach (e[i]) chk("time", host.buf_q[i], e[i]);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys_i);
        rst_i = 0;
        t_protect();
        t_charger();
        t_ram();
        t_clock();
        complete_run();
    end
endmodule // tb_serial_rtc_with_ram
